// file: design/io_bus_buffer.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module io_bus_buffer #(
	parameter int WIDTH = 72
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	logic [WIDTH-1:0] slot [2];
	logic wptr;
	logic rptr;
	logic [1:0] count;
	logic push;
	logic pop;

	assign in_ready = (count != 2'h2);
	assign out_valid = (count != 2'h0);
	assign out_data = slot[rptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			slot[0] <= '0;
			slot[1] <= '0;
		end else if (push) begin
			slot[wptr] <= in_data;
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			wptr <= 1'b0;
			rptr <= 1'b0;
			count <= 2'h0;
		end else begin
			if (push)
				wptr <= ~wptr;
			if (pop)
				rptr <= ~rptr;
			// Simultaneous push and pop leaves the fill level unchanged
			if (push && !pop)
				count <= count + 2'h1;
			else if (pop && !push)
				count <= count - 2'h1;
		end
	end
endmodule

// file: design/io_port_access_unit.sv
// I/O port access unit: port instructions to I/O and memory bus cycles
// Function
// - Separate 64K byte-port space, ports 0 to FFFFH
// - Port address past FFFFH wraps to zero
// - Adjacent byte ports form 16/32-bit ports
// - Aligned 16/32-bit port access takes one cycle
// - Unaligned port access crossing a 4-byte boundary adds a bus cycle
// - Order of split bus cycles is unspecified
// - Port write completes before instruction finishes
// - Memory/IO select high memory, low I/O
// - Command lines encode memory or I/O cycle
// - Parity errors always reported on I/O cycles
// - Port instructions issue I/O-space port cycles; string forms also issue memory cycles
// - Single transfers use accumulator by access size
// - Single port from immediate or port register
// - String port from register, source/destination pointers
// - Repeat prefix steps pointer by direction flag
// - Uncacheable ranges are never cached
// - Page cache disable flag blocks caching
`timescale 1ns/1ps
`include "io_port_defines.svh"
module io_port_access_unit #(
	parameter int COUNT_W = 32
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic REQ_VALID,
	output logic REQ_READY,
	input wire logic REQ_STRING,
	input wire logic REQ_INPUT,
	input wire logic [1:0] REQ_SIZE,
	input wire logic REQ_USE_IMM,
	input wire logic [7:0] REQ_IMM_PORT,
	input wire logic [15:0] PORT_ADDR_REG,
	input wire logic [31:0] ACCUM_32,
	input wire logic REPEAT_PREFIX,
	input wire logic [COUNT_W-1:0] REPEAT_COUNT,
	input wire logic DIRECTION_FLAG,
	input wire logic [31:0] STRING_SOURCE_PTR,
	input wire logic [31:0] STRING_DEST_PTR,
	input wire logic PAGE_CACHE_DISABLE_FLAG,
	input wire logic UNCACHEABLE_TYPE,
	input wire logic CACHE_ENABLE_IN_N,
	input wire logic PARITY_MEM_EN,
	output logic DONE,
	output logic BUSY,
	output logic [31:0] ACCUM_32_OUT,
	output logic [31:0] SRC_PTR_OUT,
	output logic [31:0] DST_PTR_OUT,
	output logic [COUNT_W-1:0] COUNT_OUT,
	output logic PARITY_FAULT,
	output logic BUS_REQ_VALID,
	input wire logic BUS_REQ_READY,
	output logic [31:0] BUS_ADDR,
	output logic [3:0] BUS_BE,
	output logic [1:0] BUS_CMD,
	output logic BUS_MEM_IO,
	output logic BUS_CACHEABLE,
	output logic [31:0] BUS_WDATA,
	input wire logic BUS_RSP_VALID,
	input wire logic [31:0] BUS_RDATA,
	input wire logic BUS_PARITY_ERR
);
	io_port_pkg::state_t state;
	logic is_string;
	logic is_input;
	logic [1:0] size;
	logic repeat_prefix;
	logic dflag;
	logic [15:0] port;
	logic [31:0] src;
	logic [31:0] dst;
	logic [COUNT_W-1:0] count;
	logic [31:0] accum;
	logic [31:0] data;
	logic [63:0] gather;
	logic piece;
	logic waiting;
	logic done;
	logic parity_fault;
	logic ken_meta;
	logic ken_sync;

	logic acc_active;
	logic acc_io;
	logic acc_write;
	logic [31:0] acc_addr;
	logic [1:0] off;
	logic [7:0] size_mask;
	logic [7:0] lane_mask;
	logic two_pieces;
	logic last_piece;
	logic [63:0] wide_wdata;
	logic [31:0] piece_addr;
	logic [3:0] piece_be;
	logic [31:0] piece_wdata;
	logic [1:0] piece_cmd;
	logic cacheable;
	logic push;
	logic buf_in_ready;
	logic [`BUS_ENTRY_W-1:0] buf_in;
	logic [`BUS_ENTRY_W-1:0] buf_out;
	logic rsp;
	logic acc_fin;
	logic [63:0] next_gather;
	logic [63:0] shifted;
	logic [31:0] data_mask;
	logic [31:0] rd_val;
	logic [31:0] step;
	logic [COUNT_W-1:0] next_count;
	logic more;

	// Cache enable arrives from a pin; two flops before anything reads it
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			ken_meta <= 1'b1;
			ken_sync <= 1'b1;
		end else begin
			ken_meta <= CACHE_ENABLE_IN_N;
			ken_sync <= ken_meta;
		end
	end

	// Which access the current state performs
	always_comb begin
		acc_active = 1'b1;
		acc_io = 1'b0;
		acc_write = 1'b0;
		acc_addr = src;
		unique case (state)
			io_port_pkg::ST_SRC_READ: begin
				acc_addr = src;
			end
			io_port_pkg::ST_PORT: begin
				acc_io = 1'b1;
				acc_write = !is_input;
				acc_addr = {16'h0000, port};
			end
			io_port_pkg::ST_DST_WRITE: begin
				acc_write = 1'b1;
				acc_addr = dst;
			end
			default: begin
				acc_active = 1'b0;
			end
		endcase
	end

	// Byte lanes of the requested range across two aligned words
	always_comb begin
		unique case (size)
			`SIZE_CODE_8: size_mask = 8'h01;
			`SIZE_CODE_16: size_mask = 8'h03;
			default: size_mask = 8'h0F;
		endcase
	end

	assign off = acc_addr[1:0];
	assign lane_mask = size_mask << off;
	// Aligned 16/32-bit accesses never touch the upper word
	assign two_pieces = |lane_mask[7:4];
	assign last_piece = piece || !two_pieces;
	assign wide_wdata = {32'h0000_0000, data} << {off, 3'b000};

	always_comb begin
		if (!piece) begin
			piece_addr = {acc_addr[31:2], 2'b00};
			piece_be = lane_mask[3:0];
			piece_wdata = wide_wdata[31:0];
		end else begin
			piece_be = lane_mask[7:4];
			piece_wdata = wide_wdata[63:32];
			if (acc_io)
				// Second word past FFFFH wraps into the bottom of the space
				piece_addr = {16'h0000,
					{port[15:2], 2'b00} + `PORT_LANE_STEP};
			else
				piece_addr = {acc_addr[31:2], 2'b00} + `BUS_LANE_STEP;
		end
	end

	// Low word always goes first; software needing order splits itself

	always_comb begin
		if (acc_io)
			piece_cmd = acc_write ? `CMD_CODE_IO_WRITE
				: `CMD_CODE_IO_READ;
		else
			piece_cmd = acc_write ? `CMD_CODE_MEM_WRITE
				: `CMD_CODE_MEM_READ;
	end

	// Port cycles are never cacheable; memory cycles obey all three blocks
	assign cacheable = !acc_io && !UNCACHEABLE_TYPE
		&& !PAGE_CACHE_DISABLE_FLAG
		&& !ken_sync;

	assign push = acc_active && !waiting;
	assign buf_in = {piece_addr, piece_be, piece_cmd, !acc_io, cacheable,
		piece_wdata};

	io_bus_buffer #(
		.WIDTH(`BUS_ENTRY_W)
	) u_buf (
		.CLK(CLK),
		.RST_N(RST_N),
		.in_valid(push),
		.in_ready(buf_in_ready),
		.in_data(buf_in),
		.out_valid(BUS_REQ_VALID),
		.out_ready(BUS_REQ_READY),
		.out_data(buf_out)
	);

	assign BUS_ADDR = buf_out[71:40];
	assign BUS_BE = buf_out[39:36];
	assign BUS_CMD = buf_out[35:34];
	assign BUS_MEM_IO = buf_out[33];
	assign BUS_CACHEABLE = buf_out[32];
	assign BUS_WDATA = buf_out[31:0];

	// One response per request, in order; only the waiting piece takes it
	assign rsp = BUS_RSP_VALID && waiting;
	assign acc_fin = rsp && last_piece;

	always_comb begin
		if (!piece)
			next_gather = {gather[63:32], BUS_RDATA};
		else
			next_gather = {BUS_RDATA, gather[31:0]};
	end

	always_comb begin
		unique case (size)
			`SIZE_CODE_8: data_mask = 32'h0000_00FF;
			`SIZE_CODE_16: data_mask = 32'h0000_FFFF;
			default: data_mask = 32'hFFFF_FFFF;
		endcase
	end

	assign shifted = next_gather >> {off, 3'b000};
	assign rd_val = shifted[31:0] & data_mask;

	always_comb begin
		unique case (size)
			`SIZE_CODE_8: step = 32'h0000_0001;
			`SIZE_CODE_16: step = 32'h0000_0002;
			default: step = 32'h0000_0004;
		endcase
	end

	assign next_count = repeat_prefix ? count - COUNT_W'(1) : count;
	assign more = is_string && repeat_prefix && (next_count != '0);

	// Piece sequencing of the current access
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			piece <= 1'b0;
			waiting <= 1'b0;
			gather <= '0;
		end else begin
			if (push && buf_in_ready)
				waiting <= 1'b1;
			else if (rsp)
				waiting <= 1'b0;
			if (rsp) begin
				gather <= next_gather;
				piece <= !last_piece;
			end
		end
	end

	// Instruction sequencing
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			state <= io_port_pkg::ST_IDLE;
			is_string <= 1'b0;
			is_input <= 1'b0;
			size <= `SIZE_CODE_8;
			repeat_prefix <= 1'b0;
			dflag <= 1'b0;
			port <= 16'h0000;
			count <= '0;
			data <= 32'h0000_0000;
		end else begin
			unique case (state)
				io_port_pkg::ST_IDLE: begin
					if (REQ_VALID) begin
						is_string <= REQ_STRING;
						is_input <= REQ_INPUT;
						size <= (REQ_SIZE == 2'h3) ? `SIZE_CODE_32 : REQ_SIZE;
						repeat_prefix <= REQ_STRING && REPEAT_PREFIX;
						dflag <= DIRECTION_FLAG;
						count <= REPEAT_COUNT;
						data <= ACCUM_32;
						if (REQ_USE_IMM && !REQ_STRING)
							port <= {8'h00, REQ_IMM_PORT};
						else
							port <= PORT_ADDR_REG;
						if (REQ_STRING && REPEAT_PREFIX && REPEAT_COUNT == '0)
							state <= io_port_pkg::ST_IDLE;
						else if (REQ_STRING && !REQ_INPUT)
							state <= io_port_pkg::ST_SRC_READ;
						else
							state <= io_port_pkg::ST_PORT;
					end
				end
				io_port_pkg::ST_SRC_READ: begin
					if (acc_fin) begin
						data <= rd_val;
						state <= io_port_pkg::ST_PORT;
					end
				end
				io_port_pkg::ST_PORT: begin
					// Leaves only on the response to the last piece, read or write
					if (acc_fin) begin
						if (is_input)
							data <= rd_val;
						if (is_input && is_string)
							state <= io_port_pkg::ST_DST_WRITE;
						else
							state <= io_port_pkg::ST_STEP_OP;
					end
				end
				io_port_pkg::ST_DST_WRITE: begin
					if (acc_fin)
						state <= io_port_pkg::ST_STEP_OP;
				end
				io_port_pkg::ST_STEP_OP: begin
					count <= next_count;
					if (more && is_input)
						state <= io_port_pkg::ST_PORT;
					else if (more)
						state <= io_port_pkg::ST_SRC_READ;
					else
						state <= io_port_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// String pointers step by element size after each element
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			src <= 32'h0000_0000;
			dst <= 32'h0000_0000;
		end else if (state == io_port_pkg::ST_IDLE && REQ_VALID) begin
			src <= STRING_SOURCE_PTR;
			dst <= STRING_DEST_PTR;
		end else if (state == io_port_pkg::ST_STEP_OP && is_string) begin
			if (!is_input)
				src <= dflag ? src - step : src + step;
			else
				dst <= dflag ? dst - step : dst + step;
		end
	end

	// Single input merges into the accumulator at its size
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			accum <= 32'h0000_0000;
		end else if (state == io_port_pkg::ST_IDLE && REQ_VALID) begin
			accum <= ACCUM_32;
		end else if (state == io_port_pkg::ST_PORT && acc_fin && is_input
			&& !is_string) begin
			accum <= (accum & ~data_mask) | rd_val;
		end
	end

	// Completion and parity reporting
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			done <= 1'b0;
			parity_fault <= 1'b0;
		end else begin
			done <= (state == io_port_pkg::ST_STEP_OP && !more)
				|| (state == io_port_pkg::ST_IDLE && REQ_VALID
				&& REQ_STRING && REPEAT_PREFIX && REPEAT_COUNT == '0);
			// No mask exists for port cycles
			parity_fault <= rsp && BUS_PARITY_ERR
				&& (acc_io || PARITY_MEM_EN);
		end
	end

	assign REQ_READY = (state == io_port_pkg::ST_IDLE);
	assign BUSY = (state != io_port_pkg::ST_IDLE);
	assign DONE = done;
	assign PARITY_FAULT = parity_fault;
	assign ACCUM_32_OUT = accum;
	assign SRC_PTR_OUT = src;
	assign DST_PTR_OUT = dst;
	assign COUNT_OUT = count;
endmodule

// file: pkg/io_port_defines.svh
// Constants for the I/O port access unit
`ifndef IO_PORT_DEFINES_SVH
`define IO_PORT_DEFINES_SVH

`define PORT_ADDR_W 16
`define PORT_SPACE_TOP 16'hFFFF
`define PORT_RSVD_LO 16'h00F8
`define PORT_RSVD_HI 16'h00FF
`define BUS_ADDR_W 32
`define BUS_DATA_W 32
`define BUS_LANE_STEP 32'h0000_0004
`define PORT_LANE_STEP 16'h0004
`define BUS_ENTRY_W 72
`define SIZE_CODE_8 2'h0
`define SIZE_CODE_16 2'h1
`define SIZE_CODE_32 2'h2
`define CMD_CODE_IO_READ 2'h0
`define CMD_CODE_IO_WRITE 2'h1
`define CMD_CODE_MEM_READ 2'h2
`define CMD_CODE_MEM_WRITE 2'h3

`endif

// file: pkg/io_port_pkg.sv
// Types for the I/O port access unit
package io_port_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SRC_READ,
		ST_PORT,
		ST_DST_WRITE,
		ST_STEP_OP
	} state_t;

	typedef enum logic [2:0] {
		ST_IDLE_X,
		ST_SRC_READ_X,
		ST_PORT_X,
		ST_DST_WRITE_X,
		ST_STEP_X
	} wide_state_t;

endpackage

// file: test/io_port_far_end.sv
// Far-side model: port decode and devices answering bus cycles
`timescale 1ns/1ps
module io_port_far_end (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic BUS_REQ_VALID,
	output logic BUS_REQ_READY,
	input wire logic [31:0] BUS_ADDR,
	input wire logic [3:0] BUS_BE,
	input wire logic [1:0] BUS_CMD,
	input wire logic BUS_CACHEABLE,
	input wire logic [31:0] BUS_WDATA,
	output logic BUS_RSP_VALID,
	output logic [31:0] BUS_RDATA,
	output logic BUS_PARITY_ERR,
	input wire logic bad_par
);
	logic [3:0] tick;
	logic [1:0] wait_n;
	logic busy;
	logic [31:0] last_addr, last_wd;
	logic [3:0] last_be;
	logic [1:0] last_cmd;
	logic [7:0] a;
	int pieces, hits;
	assign a = last_addr[7:0];
	// Stalls every other cycle so held requests get exercised
	assign BUS_REQ_READY = tick[0] && !busy;
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			tick <= 4'h0;
			busy <= 1'h0;
			wait_n <= 2'h0;
			BUS_RSP_VALID <= 1'h0;
			BUS_PARITY_ERR <= 1'h0;
			BUS_RDATA <= 32'h0;
		end else begin
			tick <= tick + 4'h1;
			BUS_RSP_VALID <= 1'h0;
			BUS_PARITY_ERR <= 1'h0;
			// Inverted every cycle between answers, so stale data never looks valid
			BUS_RDATA <= ~BUS_RDATA;
			if (BUS_REQ_VALID && BUS_REQ_READY) begin
				busy <= 1'h1;
				wait_n <= tick[2] ? 2'h3 : 2'h1;
				pieces <= pieces + 1;
				hits <= hits + int'(BUS_CACHEABLE);
				last_addr <= BUS_ADDR;
				last_be <= BUS_BE;
				last_cmd <= BUS_CMD;
				last_wd <= BUS_WDATA & {{8{BUS_BE[3]}}, {8{BUS_BE[2]}},
					{8{BUS_BE[1]}}, {8{BUS_BE[0]}}};
			end else if (busy) begin
				wait_n <= wait_n - 2'h1;
				if (wait_n == 2'h1) begin
					busy <= 1'h0;
					BUS_RSP_VALID <= 1'h1;
					BUS_PARITY_ERR <= bad_par;
					// Each byte port except F8H to FFH answers with the low byte of its own address
					if (last_cmd[1] || last_addr[15:3] != 13'h1F)
						BUS_RDATA <= {a + 8'h3, a + 8'h2, a + 8'h1, a};
				end
			end
		end
	end
endmodule

// file: test/io_port_unit_asserts.sv
// Checker for bus cycles and completion of the I/O port access unit
`timescale 1ns/1ps
module io_port_unit_asserts (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic REQ_VALID,
	input wire logic REQ_READY,
	input wire logic REQ_STRING,
	input wire logic REQ_INPUT,
	input wire logic [1:0] REQ_SIZE,
	input wire logic REQ_USE_IMM,
	input wire logic [7:0] REQ_IMM_PORT,
	input wire logic DONE,
	input wire logic PARITY_FAULT,
	input wire logic BUS_REQ_VALID,
	input wire logic BUS_REQ_READY,
	input wire logic [31:0] BUS_ADDR,
	input wire logic [3:0] BUS_BE,
	input wire logic [1:0] BUS_CMD,
	input wire logic BUS_MEM_IO,
	input wire logic BUS_CACHEABLE,
	input wire logic BUS_RSP_VALID,
	input wire logic BUS_PARITY_ERR
);
	logic pend;
	logic last_mem;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	// Kind of the open cycle is kept so parity is judged when it answers
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			pend <= 1'h0;
			last_mem <= 1'h0;
		end else if (BUS_REQ_VALID && BUS_REQ_READY) begin
			pend <= 1'h1;
			last_mem <= BUS_MEM_IO;
		end else if (BUS_RSP_VALID) begin
			pend <= 1'h0;
		end
	end
	sequence imm_out8;
		REQ_VALID && REQ_READY && !REQ_STRING && !REQ_INPUT
			&& REQ_SIZE == 2'h0 && REQ_USE_IMM;
	endsequence
	sequence io_byte_write(logic [7:0] p);
		BUS_REQ_VALID && BUS_CMD == 2'h1 && BUS_BE == 4'h1 << p[1:0]
			&& BUS_ADDR == {24'h0, p[7:2], 2'h0};
	endsequence
	AST_IMM_OUT8: assert property (
		imm_out8 |-> ##2 io_byte_write($past(REQ_IMM_PORT, 2)))
		else $error("immediate byte write wrong");
	AST_SELECT_LEVEL: assert property (
		BUS_REQ_VALID |-> BUS_MEM_IO == BUS_CMD[1])
		else $error("memory or I/O select wrong");
	AST_IO_SPACE: assert property (
		BUS_REQ_VALID && !BUS_MEM_IO |-> BUS_ADDR[31:16] == 16'h0
			&& BUS_ADDR[1:0] == 2'h0)
		else $error("I/O address outside port space");
	AST_IO_UNCACHED: assert property (
		BUS_REQ_VALID && !BUS_MEM_IO |-> !BUS_CACHEABLE)
		else $error("I/O cycle marked cacheable");
	AST_REQ_HOLD: assert property (
		BUS_REQ_VALID && !BUS_REQ_READY |=> BUS_REQ_VALID
			&& $stable(BUS_ADDR) && $stable(BUS_BE) && $stable(BUS_CMD))
		else $error("bus request changed while stalled");
	AST_ONE_OPEN: assert property (
		pend |-> !BUS_REQ_VALID)
		else $error("second bus cycle before answer");
	AST_WRITE_DONE: assert property (
		DONE |-> !pend && !BUS_REQ_VALID)
		else $error("done before bus cycles finished");
	AST_PARITY_IO: assert property (
		BUS_RSP_VALID && BUS_PARITY_ERR && pend && !last_mem |=> PARITY_FAULT)
		else $error("parity error on I/O cycle not reported");
endmodule
bind io_port_access_unit io_port_unit_asserts u_chk (.*);

// file: test/testbench.sv
// Testbench for the I/O port access unit
`timescale 1ns/1ps
module testbench;
	logic CLK = 1'h0, RST_N = 1'h0, REQ_VALID = 1'h0, REQ_STRING = 1'h0;
	logic REQ_INPUT = 1'h0, REQ_USE_IMM = 1'h0, REPEAT_PREFIX = 1'h0;
	logic DIRECTION_FLAG = 1'h0, PAGE_CACHE_DISABLE_FLAG = 1'h0;
	logic UNCACHEABLE_TYPE = 1'h0, CACHE_ENABLE_IN_N = 1'h0;
	logic PARITY_MEM_EN = 1'h0, bad_par = 1'h0;
	logic [1:0] REQ_SIZE = 2'h0;
	logic [7:0] REQ_IMM_PORT = 8'h0;
	logic [15:0] PORT_ADDR_REG = 16'h0;
	logic [31:0] ACCUM_32 = 32'h11223344, REPEAT_COUNT = 32'h0;
	logic [31:0] STRING_SOURCE_PTR = 32'h0, STRING_DEST_PTR = 32'h0;
	logic REQ_READY, DONE, BUSY, PARITY_FAULT, BUS_REQ_VALID, BUS_REQ_READY;
	logic BUS_MEM_IO, BUS_CACHEABLE, BUS_RSP_VALID, BUS_PARITY_ERR;
	logic [31:0] ACCUM_32_OUT, SRC_PTR_OUT, DST_PTR_OUT, COUNT_OUT;
	logic [31:0] BUS_ADDR, BUS_WDATA, BUS_RDATA;
	logic [3:0] BUS_BE;
	logic [1:0] BUS_CMD;
	int failures, samples_checked, cyc, base, cbase, seen_fault;
	typedef struct {
		logic inp; logic [1:0] sz; logic imm; logic [15:0] port;
		int n; logic [31:0] addr; logic [3:0] be; logic [31:0] wd;
	} row_t;
	// Single transfers: pieces, last bus cycle and data written
	row_t rows[8] = '{
		'{1'h0, 2'h0, 1'h1, 16'h0010, 1, 32'h10, 4'h1, 32'h00000044},
		'{1'h0, 2'h1, 1'h0, 16'h0002, 1, 32'h0, 4'hC, 32'h33440000},
		'{1'h0, 2'h2, 1'h0, 16'h0004, 1, 32'h4, 4'hF, 32'h11223344},
		'{1'h0, 2'h2, 1'h0, 16'h0003, 2, 32'h4, 4'h7, 32'h00112233},
		'{1'h1, 2'h2, 1'h0, 16'h0003, 2, 32'h4, 4'h7, 32'h0},
		'{1'h1, 2'h1, 1'h0, 16'hFFFF, 2, 32'h0, 4'h1, 32'h0},
		'{1'h1, 2'h0, 1'h1, 16'h007F, 1, 32'h7C, 4'h8, 32'h0},
		'{1'h1, 2'h1, 1'h0, 16'h1235, 1, 32'h1234, 4'h6, 32'h0}};
	io_port_access_unit u_dut (.*);
	io_port_far_end u_far (.*);
	initial begin
		forever #2 CLK = ~CLK;
	end
	// Ceiling well above the few hundred cycles the tests need
	// Sampled mid-cycle so the fault pulse is read while it stands
	always @(negedge CLK) begin
		cyc++;
		if (PARITY_FAULT === 1'h1)
			seen_fault++;
		if (cyc > 20000) begin
			failures++;
			finish_test();
		end
	end
	task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Input merged into the accumulator low bytes, upper bytes kept
	function automatic logic [31:0] merge(logic [1:0] z, logic [15:0] p);
		logic [31:0] r;
		r = ACCUM_32;
		for (int b = 0; b < 4; b++)
			if (b < (1 << z))
				r[8*b +: 8] = p[7:0] + 8'(b);
		return r;
	endfunction
	task automatic run(logic s, logic i, logic [1:0] z, logic m,
		logic [15:0] p);
		int k;
		REQ_STRING = s;
		REQ_INPUT = i;
		REQ_SIZE = z;
		REQ_USE_IMM = m;
		REQ_IMM_PORT = p[7:0];
		// Immediate rows see another register value, so the source shows
		PORT_ADDR_REG = m ? ~p : p;
		base = u_far.pieces;
		cbase = u_far.hits;
		REQ_VALID = 1'h1;
		@(negedge CLK);
		REQ_VALID = 1'h0;
		for (k = 0; k < 300 && DONE !== 1'h1; k++)
			@(negedge CLK);
		check("done", DONE, 1'h1);
	endtask
	initial begin
		repeat (6) @(negedge CLK);
		RST_N = 1'h1;
		check("ready", REQ_READY, 1'h1);
		check("bus idle", BUS_REQ_VALID, 1'h0);
		foreach (rows[k]) begin
			run(1'h0, rows[k].inp, rows[k].sz, rows[k].imm, rows[k].port);
			check("pieces", u_far.pieces - base, rows[k].n);
			check("addr", u_far.last_addr, rows[k].addr);
			check("be", u_far.last_be, rows[k].be);
			check("cmd", u_far.last_cmd, {1'h0, ~rows[k].inp});
			if (rows[k].inp)
				check("accum", ACCUM_32_OUT, merge(rows[k].sz, rows[k].port));
			else
				check("wdata", u_far.last_wd, rows[k].wd);
		end
		REPEAT_PREFIX = 1'h1;
		REPEAT_COUNT = 32'h3;
		DIRECTION_FLAG = 1'h1;
		STRING_SOURCE_PTR = 32'h100;
		PAGE_CACHE_DISABLE_FLAG = 1'h1;
		run(1'h1, 1'h0, 2'h1, 1'h0, 16'h0020);
		check("str out pieces", u_far.pieces - base, 6);
		check("src ptr", SRC_PTR_OUT, 32'hFA);
		check("count", COUNT_OUT, 32'h0);
		check("port", u_far.last_addr, 32'h20);
		check("page uncached", u_far.hits - cbase, 0);
		PAGE_CACHE_DISABLE_FLAG = 1'h0;
		UNCACHEABLE_TYPE = 1'h1;
		DIRECTION_FLAG = 1'h0;
		REPEAT_COUNT = 32'h2;
		STRING_DEST_PTR = 32'h200;
		run(1'h1, 1'h1, 2'h0, 1'h0, 16'h0020);
		check("str in pieces", u_far.pieces - base, 4);
		check("dst ptr", DST_PTR_OUT, 32'h202);
		check("mem write", u_far.last_cmd, 2'h3);
		check("dst data", u_far.last_wd, 32'h00002000);
		check("range uncached", u_far.hits - cbase, 0);
		UNCACHEABLE_TYPE = 1'h0;
		CACHE_ENABLE_IN_N = 1'h1;
		REPEAT_PREFIX = 1'h0;
		repeat (3) @(negedge CLK);
		run(1'h1, 1'h1, 2'h0, 1'h0, 16'h0020);
		check("one element", u_far.pieces - base, 2);
		check("pin uncached", u_far.hits - cbase, 0);
		// Every block lifted: the memory write may now be cached
		CACHE_ENABLE_IN_N = 1'h0;
		repeat (3) @(negedge CLK);
		run(1'h1, 1'h1, 2'h0, 1'h0, 16'h0020);
		check("cached write", u_far.hits - cbase, 1);
		REPEAT_PREFIX = 1'h1;
		REPEAT_COUNT = 32'h0;
		run(1'h1, 1'h0, 2'h2, 1'h0, 16'h0020);
		check("zero count", u_far.pieces - base, 0);
		// DONE comes at once here; let an edge pass before the next request
		@(negedge CLK);
		bad_par = 1'h1;
		run(1'h0, 1'h1, 2'h0, 1'h0, 16'h0040);
		check("parity", seen_fault, 1);
		// String input: memory parity counts only when enabled
		REPEAT_PREFIX = 1'h0;
		run(1'h1, 1'h1, 2'h0, 1'h0, 16'h0040);
		check("mem parity masked", seen_fault, 2);
		PARITY_MEM_EN = 1'h1;
		run(1'h1, 1'h1, 2'h0, 1'h0, 16'h0040);
		check("mem parity", seen_fault, 4);
		bad_par = 1'h0;
		PARITY_MEM_EN = 1'h0;
		// Reset in the middle of a block transfer must clear the bus side
		REPEAT_PREFIX = 1'h1;
		REPEAT_COUNT = 32'h3;
		REQ_VALID = 1'h1;
		@(negedge CLK);
		REQ_VALID = 1'h0;
		repeat (5) @(negedge CLK);
		check("mid block", BUSY, 1'h1);
		RST_N = 1'h0;
		#1;
		check("reset busy", BUSY, 1'h0);
		check("reset bus", BUS_REQ_VALID, 1'h0);
		check("reset done", DONE, 1'h0);
		check("reset count", COUNT_OUT, 32'h0);
		@(negedge CLK);
		RST_N = 1'h1;
		REPEAT_PREFIX = 1'h0;
		// Size code 3 is taken as a 32-bit access
		run(1'h0, 1'h1, 2'h3, 1'h0, 16'h0008);
		check("after reset", ACCUM_32_OUT, merge(2'h2, 16'h0008));
		finish_test();
	end
endmodule
